// *** design/slave_serial_port_pkg.sv ***
package slave_serial_port_pkg;
   // register map
   localparam logic [11:0] ADDR_CSR = 12'h000;
   localparam logic [11:0] ADDR_MASK = 12'h004;
   localparam logic [11:0] ADDR_WAKE = 12'h008;
   // control and status field positions
   localparam int BIT_IRQ = 15;
   localparam int BIT_INTERRUPT_GATE_BIT = 14;
   localparam int BIT_SELPOL = 13;
   localparam int BIT_FULL = 12;
   localparam int BIT_OVR = 11;
   localparam int BIT_PHA = 10;
   localparam int BIT_POL = 9;
   localparam int BIT_EN = 8;
   localparam logic [15:0] CSR_RESET = 16'h0000;
   localparam logic [15:0] CSR_WR_MASK = 16'h67ff;
   localparam int BYTE_BITS = 8;
   localparam int WAKE_BIT = 0;
   localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_SHIFT = 2'b11
   } rx_state_e;
endpackage : slave_serial_port_pkg

// *** design/spi_slave_receiver.sv ***
//Contract
//- three input wires: shift clock, select, data in; nothing driven back.
//- eighth clock copies shift register to buffer and sets interrupt flag in the same cycle.
//- received byte sits in low eight bits of status register.
//- capture-edge select 0 samples leading edge, 1 trailing edge.
//- idle-level select gives clock idle level; edges relative to it.
//- select-active-level 0 active low, 1 active high; resets to 0.
//- edges are acted on only while select is active.
//- interrupt flag set each byte, cleared by writing one.
//- interrupt gate bit gates request; reset clears it.
//- buffer-full set on each new byte, cleared when data read.
//- new byte onto unread buffer sets overrun and posts interrupt.
//- overrun clears when data read.
//- unread byte is replaced by the next one.
//- receive logic keeps working while system is asleep.
//- in sleep, received byte requests wake if wake source bit set.
//- module enable bit 1 on, 0 off; off by default.
//- reset clears the whole control and status register.
`timescale 1ns/1ps
module spi_slave_receiver
   import slave_serial_port_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic paddr_in_unused_dummy_never,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_shift_clock,
   input wire logic slave_select_in,
   input wire logic serial_data_in,
   input wire logic sleep_mode,
   output logic slave_interrupt_request,
   output logic wake_request
);
   import slave_serial_port_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // link inputs enter through a two-stage synchroniser
   logic [2:0] link_sync;
   sync2 #(.W(3)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({external_shift_clock, slave_select_in, serial_data_in}),
      .sync_out(link_sync)
   );

   typedef struct packed {
      logic [15:0] csr;
      logic wake_en;
      rx_state_e state;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic sclk_d;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
      logic wake;
   } state_s;
   state_s st_r, st_nxt;

   logic sclk_s, sel_raw, din_s;
   logic sel_act, rise, fall, lead, trail, cap;
   logic acc, wr, rd, hit_csr, hit_wake, byte_done, data_read;
   logic [7:0] shifted;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sclk_s = link_sync[2];
      sel_raw = link_sync[1];
      din_s = link_sync[0];
      st_nxt = st_r;
      sel_act = st_r.csr[BIT_SELPOL] ? sel_raw : ~sel_raw;
      rise = sclk_s & ~st_r.sclk_d;
      fall = ~sclk_s & st_r.sclk_d;
      // leading edge leaves the idle level
      lead = st_r.csr[BIT_POL] ? fall : rise;
      trail = st_r.csr[BIT_POL] ? rise : fall;
      cap = st_r.csr[BIT_PHA] ? trail : lead;
      shifted = {st_r.shreg[6:0], din_s}; // msb first
      acc = psel & penable;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      hit_csr = (paddr == ADDR_CSR);
      hit_wake = (paddr == ADDR_WAKE);
      data_read = rd & hit_csr;
      byte_done = 1'b0;
      st_nxt.sclk_d = sclk_s;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;

      // read clears the data flags; a byte landing now overrides below
      if (data_read) begin
         st_nxt.csr[BIT_FULL] = 1'b0;
         st_nxt.csr[BIT_OVR] = 1'b0;
      end
      if (wr & hit_csr) begin
         st_nxt.csr = (st_r.csr & ~CSR_WR_MASK) | (pwdata[15:0] & CSR_WR_MASK);
         // write-one-to-clear of the interrupt flag
         if (pwdata[BIT_IRQ]) begin
            st_nxt.csr[BIT_IRQ] = 1'b0;
         end
         st_nxt.csr[BIT_FULL] = st_r.csr[BIT_FULL];
         st_nxt.csr[BIT_OVR] = st_r.csr[BIT_OVR];
         st_nxt.csr[7:0] = st_r.csr[7:0];
      end
      if (wr & hit_wake) begin
         st_nxt.wake_en = pwdata[WAKE_BIT];
      end

      // receive machine; sampling runs off the synchronised link only
      case (st_r.state)
         ST_OFF: begin
            st_nxt.bitcnt = '0;
            if (st_r.csr[BIT_EN]) begin
               st_nxt.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            st_nxt.bitcnt = '0;
            if (!st_r.csr[BIT_EN]) begin
               st_nxt.state = ST_OFF;
            end else if (sel_act) begin
               st_nxt.state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!st_r.csr[BIT_EN]) begin
               st_nxt.state = ST_OFF;
               st_nxt.bitcnt = '0;
            end else if (!sel_act) begin
               st_nxt.state = ST_WAIT;
               st_nxt.bitcnt = '0;
            end else if (cap) begin
               st_nxt.shreg = shifted;
               if (st_r.bitcnt == 4'(BYTE_BITS - 1)) begin
                  st_nxt.bitcnt = '0;
                  byte_done = 1'b1;
               end else begin
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               end
            end
         end
         default: begin
            st_nxt.state = ST_OFF;
         end
      endcase

      // byte landing wins over any clear in the same cycle
      if (byte_done) begin
         st_nxt.csr[7:0] = shifted;
         st_nxt.csr[BIT_FULL] = 1'b1;
         if (st_r.csr[BIT_FULL] & ~data_read) begin
            st_nxt.csr[BIT_OVR] = 1'b1;
         end
         st_nxt.csr[BIT_IRQ] = 1'b1;
      end

      // apb: single wait-free access phase, registered answer
      if (psel & ~penable) begin
         st_nxt.ready = 1'b1;
         st_nxt.err = ~(paddr == ADDR_CSR || paddr == ADDR_MASK || paddr == ADDR_WAKE);
         if (paddr == ADDR_CSR) begin
            st_nxt.rdata = {16'h0000, st_r.csr};
         end else if (paddr == ADDR_MASK) begin
            st_nxt.rdata = {31'h0000_0000, st_r.csr[BIT_INTERRUPT_GATE_BIT]};
         end else if (paddr == ADDR_WAKE) begin
            st_nxt.rdata = {31'h0000_0000, st_r.wake_en};
         end else begin
            st_nxt.rdata = APB_ERR_DATA;
         end
      end
      if (wr & (paddr == ADDR_MASK)) begin
         st_nxt.csr[BIT_INTERRUPT_GATE_BIT] = pwdata[0];
      end

      st_nxt.irq = st_nxt.csr[BIT_IRQ] & st_nxt.csr[BIT_INTERRUPT_GATE_BIT];
      st_nxt.wake = sleep_mode & st_r.wake_en & st_nxt.csr[BIT_IRQ];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0; // csr clears to zero
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign slave_interrupt_request = st_r.irq;
   assign wake_request = st_r.wake;
endmodule : spi_slave_receiver

// *** design/sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 3
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;
   sync_s st_r, st_nxt;
   // first stage feeds only the second
   always_comb begin
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign sync_out = st_r.s2;
endmodule : sync2

// *** sim/slave_serial_port_master_model.sv ***
`timescale 1ns/1ps
module slave_serial_port_master_model
   import slave_serial_port_pkg::*;
(
   output logic external_shift_clock,
   output logic slave_select_in,
   output logic serial_data_in
);
   // three wires toward the slave, nothing comes back
   initial begin
      external_shift_clock = 1'b0;
      slave_select_in = 1'b1;
      serial_data_in = 1'b0;
   end
   // select goes inactive before the idle level moves, so no stray edge counts
   task automatic send(input logic [7:0] b, input logic [15:0] c, input logic act);
      slave_select_in = !c[BIT_SELPOL];
      #200 external_shift_clock = c[BIT_POL];
      #200 slave_select_in = c[BIT_SELPOL] ~^ act;
      for (int i = 7; i >= 0; i--) begin
         if (!c[BIT_PHA]) serial_data_in = b[i];
         #80 external_shift_clock = !c[BIT_POL];
         if (c[BIT_PHA]) serial_data_in = b[i];
         #80 external_shift_clock = c[BIT_POL];
      end
      #400 slave_select_in = !c[BIT_SELPOL];
      serial_data_in = !serial_data_in;
   endtask : send
endmodule : slave_serial_port_master_model

// *** sim/slave_serial_port_monitor.sv ***
`timescale 1ns/1ps
module slave_serial_port_monitor
   import slave_serial_port_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep_mode,
   input wire logic slave_interrupt_request,
   input wire logic wake_request
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire setup = psel && !penable;
   wire mapped = paddr inside {ADDR_CSR, ADDR_MASK, ADDR_WAKE};
   wire irq = slave_interrupt_request;
   // the request is registered, so a closed gate shows one edge later
   wire gate_off = pready && pwrite && paddr == ADDR_CSR && !pwdata[BIT_INTERRUPT_GATE_BIT];
   a_ready_next: assert property (setup |=> pready) else $error("late ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("no error");
   a_err_mapped: assert property (setup && mapped |=> !pslverr) else $error("false error");
   a_gate_off: assert property (gate_off |=> ##1 !irq) else $error("gate ignored");
   a_wake_awake: assert property (!sleep_mode [*4] |-> !wake_request) else $error("woke");
   a_reset_quiet: assert property ($fell(sys_rst) |-> !irq) else $error("irq at reset");
endmodule : slave_serial_port_monitor
bind spi_slave_receiver slave_serial_port_monitor mon_u (.*);

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import slave_serial_port_pkg::*;
   logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_mode = 1'b0, pready, pslverr, slave_interrupt_request, wake_request;
   logic external_shift_clock, slave_select_in, serial_data_in;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] c = 16'h0;
   logic [7:0] d;
   int n_fail, check_count, cyc;
   spi_slave_receiver dut_u (.*, .paddr_in_unused_dummy_never(1'b0));
   slave_serial_port_master_model m_u (.*);
   task automatic complete_run;
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one transfer; a read is compared with e at the edge that samples pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w) chk(prdata, e);
      chk({31'h0, pslverr}, {31'h0, !(a inside {ADDR_CSR, ADDR_MASK, ADDR_WAKE})});
   endtask : apb
   initial forever #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc == 20000) begin
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      apb(1'b0, ADDR_CSR, 32'h0, 32'h0);
      apb(1'b0, 12'h00c, 32'h0, APB_ERR_DATA);
      m_u.send(8'ha5, c, 1'b1);
      apb(1'b0, ADDR_CSR, 32'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         c = 16'h0100 | 16'(i << 9) | (i == 3 ? 16'h2000 : 16'h0);
         d = 8'h4b ^ 8'(i * 33);
         apb(1'b1, ADDR_CSR, {16'h0, c | 16'h8000}, 32'h0);
         m_u.send(~d, c, 1'b0);
         m_u.send(d, c, 1'b1);
         apb(1'b0, ADDR_CSR, 32'h0, {16'h0, c[15:8] | 8'h90, d});
      end
      m_u.send(8'h81, c, 1'b1);
      m_u.send(8'h7e, c, 1'b1);
      apb(1'b0, ADDR_CSR, 32'h0, {16'h0, c[15:8] | 8'h98, 8'h7e});
      apb(1'b0, ADDR_CSR, 32'h0, {16'h0, c[15:8] | 8'h80, 8'h7e});
      apb(1'b1, ADDR_CSR, {16'h0, c | 16'h4000}, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, slave_interrupt_request}, 32'h1);
      apb(1'b0, ADDR_MASK, 32'h0, 32'h1);
      apb(1'b1, ADDR_CSR, {16'h0, c | 16'hc000}, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, slave_interrupt_request}, 32'h0);
      apb(1'b1, ADDR_WAKE, 32'h1, 32'h0);
      sleep_mode <= 1'b1;
      m_u.send(8'h5a, c, 1'b1);
      @(posedge ref_clk);
      chk({30'h0, wake_request, slave_interrupt_request}, 32'h3);
      complete_run();
   end
endmodule : tb_top
